// *** hdl/eeprom_pe_pkg.sv ***
// Purpose: Shared constants for the EEPROM program/erase controller
// Assumes: 125 MHz system clock, byte-wide internal bus
// Notes: Addresses are byte offsets within the controller's own space
package eeprom_pe_pkg;
	localparam int ARRAY_BYTES = 512;
	localparam int ADDR_W = 10;
	localparam int BLOCK_BYTES = 128;
	localparam int NUM_BLOCKS = 4;
	// Address map: array at 0x000-0x1ff, nonvolatile cells above it
	localparam logic [9:0] ARRAY_LAST = 10'h1ff;
	localparam logic [9:0] NV_DIV_HIGH_ADDR = 10'h200;
	localparam logic [9:0] NV_DIV_LOW_ADDR = 10'h201;
	localparam logic [9:0] NV_PROT_ADDR = 10'h202;
	// Secured window inside the array
	localparam logic [9:0] SECURE_FIRST = 10'h0f0;
	localparam logic [9:0] SECURE_LAST = 10'h0ff;
	// Field positions
	localparam int PROT_SEC_BIT = 4;
	localparam int DIVH_SEC_BIT = 7;
	localparam int CR_PGM_BIT = 0;
	localparam int CR_AUTO_BIT = 1;
	localparam int CR_LAT_BIT = 2;
	localparam int CR_MODE_LO_BIT = 3;
	localparam int CR_MODE_HI_BIT = 4;
	localparam int CR_OFF_BIT = 5;
	localparam int CR_SPARE_BIT = 7;
	// Reset and erased values
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] CR_RESET = 8'h00;
	localparam logic [7:0] DIVH_VALID_MASK = 8'h87;
	// Timebase
	localparam int CLK_MHZ = 125;
	localparam int TIMEBASE_NS = 35000;
	localparam int AUTO_TICKS = 8;
	typedef enum logic [1:0] {
		MODE_BYTE_PGM, MODE_BYTE_ERASE, MODE_BLOCK_ERASE, MODE_BULK_ERASE
	} op_mode_e;
endpackage : eeprom_pe_pkg

// *** hdl/timebase_tick.sv ***
// Purpose: Divides the chosen reference clock down to the 35 us tick
// Assumes: Both reference enables are synchronous to ref_clk
// Notes: A zero divider value stalls the tick rather than running wild
`timescale 1ns/1ps
module timebase_tick #(
	parameter int DIV_W = 11
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic osc_clk_en,
	input wire logic bus_clk_en,
	input wire logic timebase_clock_select,
	input wire logic [DIV_W-1:0] timebase_divider,
	output logic tick
);
	logic [DIV_W-1:0] cnt_ff;
	logic src_en;

	// Select reference pulse stream
	assign src_en = timebase_clock_select ? bus_clk_en : osc_clk_en;

	// Count reference pulses, emit one tick per divider period
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !run) begin
			cnt_ff <= '0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (src_en && timebase_divider != '0) begin
				if (cnt_ff >= timebase_divider - 1'b1) begin
					cnt_ff <= '0;
					tick <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end
endmodule : timebase_tick

// *** hdl/eeprom_pe_ctrl.sv ***
// Purpose: Program/erase controller and storage for a 512-byte EEPROM
// Assumes: CPU bus reads/writes are single-cycle strobes on ref_clk
// Notes: The charge pump is modelled by pump_on; cells change at cycle end
`timescale 1ns/1ps
module eeprom_pe_ctrl
	import eeprom_pe_pkg::*;
#(
	parameter int DIV_W = 11,
	parameter int AUTO_LEN = eeprom_pe_pkg::AUTO_TICKS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic osc_clk_en,
	input wire logic bus_clk_en,
	input wire logic timebase_clock_select,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [eeprom_pe_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	input wire logic pe_control_wr,
	input wire logic [7:0] pe_control_wdata,
	output logic [7:0] pe_control_reg,
	input wire logic divider_high_wr,
	input wire logic divider_low_wr,
	input wire logic [7:0] divider_wdata,
	output logic [7:0] divider_high,
	output logic [7:0] divider_low,
	output logic [7:0] active_protection_reg,
	output logic pump_on,
	output logic op_refused
);
	import eeprom_pe_pkg::*;

	// Delivered state: array and nonvolatile cells blank; reset leaves them
	logic [7:0] mem_ff [ARRAY_BYTES] = '{default: ERASED_BYTE};
	logic [7:0] nv_divider_high = ERASED_BYTE;
	logic [7:0] nv_divider_low = ERASED_BYTE;
	logic [7:0] nv_protection_reg = ERASED_BYTE;
	logic [7:0] divh_ff, divl_ff, acr_ff, cr_ff;
	logic [ADDR_W-1:0] lat_addr_ff;
	logic [7:0] lat_data_ff;
	logic lat_valid_ff, refused_ff, tick, rst_n_seen_ff;
	logic [7:0] auto_cnt_ff;
	logic pgm_fall, auto_done, target_ok, pgm_prev_ff;
	logic [1:0] op_mode;
	logic security_arm, divider_security;

	// Decode: a nonvolatile config cell address
	function automatic logic is_nv(input logic [ADDR_W-1:0] a);
		return a == NV_DIV_HIGH_ADDR || a == NV_DIV_LOW_ADDR ||
			a == NV_PROT_ADDR;
	endfunction : is_nv

	// Decode: address inside the 16 secured bytes
	function automatic logic is_secure(input logic [ADDR_W-1:0] a);
		return a >= SECURE_FIRST && a <= SECURE_LAST;
	endfunction : is_secure

	// Security comes from the active copies; only reset refreshes the protection bit, a divider high write can also change the divider bit
	assign security_arm = ~acr_ff[PROT_SEC_BIT];
	assign divider_security = ~divh_ff[DIVH_SEC_BIT];
	assign op_mode = cr_ff[CR_MODE_HI_BIT:CR_MODE_LO_BIT];
	assign pe_control_reg = cr_ff;
	assign divider_high = divh_ff;
	assign divider_low = divl_ff;
	assign active_protection_reg = acr_ff;
	assign op_refused = refused_ff;
	assign pump_on = cr_ff[CR_PGM_BIT] & ~target_ok ? 1'b0 :
		cr_ff[CR_PGM_BIT];

	// Is the latched target allowed for the chosen mode?
	always_comb begin
		logic [1:0] blk;
		blk = lat_addr_ff[8:7];
		target_ok = 1'b1;
		if (lat_addr_ff == NV_PROT_ADDR) begin
			target_ok = !security_arm && op_mode[1] == 1'b0;
		end else if (is_nv(lat_addr_ff)) begin
			target_ok = !divider_security && op_mode[1] == 1'b0;
		end else if (op_mode == MODE_BULK_ERASE) begin
			target_ok = !security_arm && acr_ff[3:0] == 4'h0;
		end else begin
			target_ok = !acr_ff[blk];
			if (op_mode == MODE_BLOCK_ERASE && security_arm) begin
				target_ok = 1'b0;
			end
			if (is_secure(lat_addr_ff) && security_arm) begin
				target_ok = 1'b0;
			end
		end
	end

	// Timebase for auto-terminated cycles
	timebase_tick #(.DIV_W(DIV_W)) u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(cr_ff[CR_PGM_BIT] & cr_ff[CR_AUTO_BIT]),
		.osc_clk_en(osc_clk_en),
		.bus_clk_en(bus_clk_en),
		.timebase_clock_select(timebase_clock_select),
		.timebase_divider({divh_ff[DIV_W-9:0], divl_ff}),
		.tick(tick)
	);

	// Auto timer counts timebase ticks while the enable bit is set
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !cr_ff[CR_PGM_BIT]) begin
			auto_cnt_ff <= 8'h00;
		end else if (tick) begin
			auto_cnt_ff <= auto_cnt_ff + 8'h01;
		end
	end
	assign auto_done = cr_ff[CR_PGM_BIT] && cr_ff[CR_AUTO_BIT] && tick &&
		auto_cnt_ff == 8'(AUTO_LEN - 1);

	// Control register: reset clears, enable gated by latch state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cr_ff <= CR_RESET;
		end else if (pe_control_wr) begin
			cr_ff <= pe_control_wdata & 8'hbf;
			if (pe_control_wdata[CR_PGM_BIT] &&
				!(cr_ff[CR_LAT_BIT] && lat_valid_ff)) begin
				cr_ff[CR_PGM_BIT] <= 1'b0;
			end
			if (cr_ff[CR_PGM_BIT]) begin
				cr_ff[CR_LAT_BIT] <= 1'b1;
			end
		end else if (auto_done) begin
			cr_ff[CR_PGM_BIT] <= 1'b0;
		end
	end

	// Address/data latch: the last valid write wins
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !cr_ff[CR_LAT_BIT]) begin
			lat_valid_ff <= 1'b0;
			lat_addr_ff <= '0;
			lat_data_ff <= ERASED_BYTE;
		end else if (mem_wr && !cr_ff[CR_PGM_BIT] &&
			(mem_addr <= ARRAY_LAST || is_nv(mem_addr))) begin
			lat_valid_ff <= 1'b1;
			lat_addr_ff <= mem_addr;
			lat_data_ff <= mem_wdata;
		end
	end

	// Falling edge of the enable commits the cell change
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pgm_prev_ff <= 1'b0;
		end else begin
			pgm_prev_ff <= cr_ff[CR_PGM_BIT];
		end
	end
	assign pgm_fall = pgm_prev_ff && !cr_ff[CR_PGM_BIT];

	// Refusal flag shows whether the target was refused when the enable rose
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			refused_ff <= 1'b0;
		end else if (cr_ff[CR_PGM_BIT] && !pgm_prev_ff) begin
			refused_ff <= !target_ok;
		end
	end

	// Array cells: program ANDs, erase sets over byte, block or all
	always_ff @(posedge ref_clk) begin
		if (pgm_fall && target_ok && lat_addr_ff <= ARRAY_LAST) begin
			for (int i = 0; i < ARRAY_BYTES; i++) begin
				case (op_mode)
					MODE_BYTE_PGM: begin
						if (10'(i) == lat_addr_ff) begin
							mem_ff[i] <= mem_ff[i] & lat_data_ff;
						end
					end
					MODE_BYTE_ERASE: begin
						if (10'(i) == lat_addr_ff) begin
							mem_ff[i] <= ERASED_BYTE;
						end
					end
					MODE_BLOCK_ERASE: begin
						if (2'(i / BLOCK_BYTES) == lat_addr_ff[8:7]) begin
							mem_ff[i] <= ERASED_BYTE;
						end
					end
					default: begin
						mem_ff[i] <= ERASED_BYTE;
					end
				endcase
			end
		end
	end

	// Nonvolatile config cells, same commit path as the array
	always_ff @(posedge ref_clk) begin
		if (pgm_fall && target_ok && is_nv(lat_addr_ff)) begin
			if (lat_addr_ff == NV_PROT_ADDR) begin
				nv_protection_reg <= op_mode == MODE_BYTE_PGM ?
					nv_protection_reg & lat_data_ff : ERASED_BYTE;
			end else if (lat_addr_ff == NV_DIV_HIGH_ADDR) begin
				nv_divider_high <= op_mode == MODE_BYTE_PGM ?
					nv_divider_high & lat_data_ff : ERASED_BYTE;
			end else begin
				nv_divider_low <= op_mode == MODE_BYTE_PGM ?
					nv_divider_low & lat_data_ff : ERASED_BYTE;
			end
		end
	end

	// Active protection copy: reset load, or read of the nonvolatile cell
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			acr_ff <= 8'h00;
		end else if (!rst_n_seen_ff) begin
			acr_ff <= nv_protection_reg;
		end else if (mem_rd && mem_addr == NV_PROT_ADDR &&
			!cr_ff[CR_LAT_BIT]) begin
			// Security bit is kept; only protect bits refresh
			acr_ff[3:0] <= nv_protection_reg[3:0];
		end
	end

	// Load happens on the first clock after reset releases
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rst_n_seen_ff <= 1'b0;
		end else begin
			rst_n_seen_ff <= 1'b1;
		end
	end

	// Active divider: reset load, then writable unless secured
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			divh_ff <= 8'h00;
			divl_ff <= 8'h00;
		end else if (!rst_n_seen_ff) begin
			divh_ff <= nv_divider_high & DIVH_VALID_MASK;
			divl_ff <= nv_divider_low;
		end else if (!divider_security) begin
			if (divider_high_wr) begin
				divh_ff <= divider_wdata & DIVH_VALID_MASK;
			end
			if (divider_low_wr) begin
				divl_ff <= divider_wdata;
			end
		end
	end

	// Read path; latched data shows while latch mode is on and a write is latched
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mem_rdata <= 8'h00;
		end else if (mem_rd) begin
			if (cr_ff[CR_LAT_BIT] && lat_valid_ff) begin
				mem_rdata <= lat_data_ff;
			end else if (mem_addr <= ARRAY_LAST) begin
				mem_rdata <= mem_ff[mem_addr[8:0]];
			end else if (mem_addr == NV_PROT_ADDR) begin
				mem_rdata <= nv_protection_reg;
			end else if (mem_addr == NV_DIV_HIGH_ADDR) begin
				mem_rdata <= nv_divider_high;
			end else if (mem_addr == NV_DIV_LOW_ADDR) begin
				mem_rdata <= nv_divider_low;
			end else begin
				mem_rdata <= 8'h00;
			end
		end
	end

	// Enable never rises without latch and a valid address
	chk_pgm_needs_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(cr_ff[CR_PGM_BIT]) |-> $past(cr_ff[CR_LAT_BIT] && lat_valid_ff))
		else $error("enable set without latch");

	// Joint clear keeps latch set
	chk_joint_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(cr_ff[CR_PGM_BIT]) && $past(pe_control_wr) |->
		cr_ff[CR_LAT_BIT])
		else $error("latch dropped with enable");

	// Divider locked while secured
	chk_div_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rst_n_seen_ff && divider_security |=> $stable({divh_ff, divl_ff}))
		else $error("divider changed while secured");

	// Secured bytes never allowed once armed
	chk_secure_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
		security_arm && is_secure(lat_addr_ff) |-> !target_ok)
		else $error("secured byte allowed");

	// Armed security blocks multi-byte erase
	chk_no_bulk: assert property (@(posedge ref_clk) disable iff (!rst_n)
		security_arm && op_mode[1] && !is_nv(lat_addr_ff) |-> !target_ok)
		else $error("block or bulk erase while armed");

	// Security stays armed
	chk_arm_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(rst_n_seen_ff) && $past(security_arm) |-> security_arm)
		else $error("security disarmed");

	// Auto mode clears enable right after the final tick
	chk_auto_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		auto_done && !pe_control_wr |=> !cr_ff[CR_PGM_BIT])
		else $error("auto did not clear enable");

	// Protected block target refused
	chk_block_prot: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lat_addr_ff <= ARRAY_LAST && acr_ff[lat_addr_ff[8:7]] |-> !target_ok)
		else $error("protected block allowed");

	// Latched target frozen while the enable is up
	chk_latch_frozen: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$past(cr_ff[CR_PGM_BIT]) |-> $stable({lat_addr_ff, lat_data_ff}))
		else $error("latch changed during cycle");

	// Enable only drops by a control write or the auto timer
	chk_pgm_fall_cause: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$fell(cr_ff[CR_PGM_BIT]) |-> $past(pe_control_wr || auto_done))
		else $error("enable dropped by itself");

	// Armed security freezes the nonvolatile protection cell
	chk_nv_prot_locked: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n_seen_ff && security_arm |=> $stable(nv_protection_reg))
		else $error("protection cell changed while armed");
endmodule : eeprom_pe_ctrl

// *** bench/cpu_bus_model.sv ***
// Purpose: CPU side of the internal bus, driving strobes on ref_clk
// Assumes: Strobes are driven 1 ns after a rising edge, one cycle each
// Notes: Sequences follow latch, target, enable, clear enable, clear latch
`timescale 1ns/1ps
module cpu_bus_model (
	input wire logic ref_clk,
	input wire logic pump_on,
	input wire logic op_refused,
	input wire logic [7:0] pe_control_reg,
	input wire logic [7:0] mem_rdata,
	output logic mem_wr,
	output logic mem_rd,
	output logic [9:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic pe_control_wr,
	output logic [7:0] pe_control_wdata,
	output logic divider_high_wr,
	output logic divider_low_wr,
	output logic [7:0] divider_wdata
);
	// Idle bus at time zero
	initial begin
		{mem_wr, mem_rd, pe_control_wr, divider_high_wr} = 4'h0;
		{divider_low_wr, mem_addr, mem_wdata} = 19'h0;
		{pe_control_wdata, divider_wdata} = 16'h0;
	end
	// One control register write
	task automatic cw(input logic [7:0] v);
		@(posedge ref_clk);
		#1 pe_control_wr = 1'b1;
		pe_control_wdata = v;
		@(posedge ref_clk);
		#1 pe_control_wr = 1'b0;
	endtask : cw
	// One memory write or read; read data lands one edge later
	task automatic mw(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 mem_wr = 1'b1;
		mem_addr = a;
		mem_wdata = d;
		@(posedge ref_clk);
		#1 mem_wr = 1'b0;
	endtask : mw
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1 mem_rd = 1'b1;
		mem_addr = a;
		@(posedge ref_clk);
		#1 mem_rd = 1'b0;
		d = mem_rdata;
	endtask : rd
	// Divider load, before any cycle is started
	task automatic dw(input logic hi, input logic [7:0] v);
		@(posedge ref_clk);
		#1 divider_high_wr = hi;
		divider_low_wr = !hi;
		divider_wdata = v;
		@(posedge ref_clk);
		#1 {divider_high_wr, divider_low_wr} = 2'b00;
	endtask : dw
	// Full cycle; callers only program bits still at one
	task automatic op(input logic [1:0] m, input logic au,
		input logic [9:0] a, input logic [7:0] d,
		output logic pumped, output logic refused);
		int n;
		cw({3'h0, m, 1'b1, au, 1'b0});
		mw(a, d);
		cw({3'h0, m, 1'b1, au, 1'b1});
		@(posedge ref_clk);
		#1 pumped = pump_on;
		refused = op_refused;
		n = 0;
		if (au) begin
			while (pe_control_reg[0] !== 1'b0 && n < 300) begin
				@(posedge ref_clk);
				#1 n++;
			end
		end else begin
			repeat (3) @(posedge ref_clk);
			cw({3'h0, m, 3'b100});
		end
		cw(8'h00);
		if (n >= 300) pumped = 1'bx;
	endtask : op
endmodule : cpu_bus_model

// *** bench/eeprom_program_erase_control_tb.sv ***
// Purpose: Self-checking bench for the EEPROM program/erase controller
// Assumes: Nonvolatile cells start blank, oscillator pulse every cycle
// Notes: AUTO_LEN is cut to one tick to keep timed cycles short
`timescale 1ns/1ps
module eeprom_program_erase_control_tb;
	import eeprom_pe_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic mem_wr, mem_rd, pe_control_wr, divider_high_wr, divider_low_wr;
	logic [9:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata, pe_control_wdata, pe_control_reg;
	logic [7:0] divider_wdata, divider_high, divider_low;
	logic [7:0] active_protection_reg, d;
	logic pump_on, op_refused, p, r;
	logic osc_clk_en = 1'b1;
	logic bus_clk_en = 1'b0;
	logic timebase_clock_select = 1'b0;
	int miscompares = 0;
	int compares = 0;
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	eeprom_pe_ctrl #(.AUTO_LEN(1)) eeprom_pe_ctrl_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .osc_clk_en(osc_clk_en),
		.bus_clk_en(bus_clk_en),
		.timebase_clock_select(timebase_clock_select),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.pe_control_wr(pe_control_wr), .pe_control_wdata(pe_control_wdata),
		.pe_control_reg(pe_control_reg), .divider_high_wr(divider_high_wr),
		.divider_low_wr(divider_low_wr), .divider_wdata(divider_wdata),
		.divider_high(divider_high), .divider_low(divider_low),
		.active_protection_reg(active_protection_reg),
		.pump_on(pump_on), .op_refused(op_refused));
	cpu_bus_model cpu_bus_model_inst (
		.ref_clk(ref_clk), .pump_on(pump_on), .op_refused(op_refused),
		.pe_control_reg(pe_control_reg), .mem_rdata(mem_rdata),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .pe_control_wr(pe_control_wr),
		.pe_control_wdata(pe_control_wdata),
		.divider_high_wr(divider_high_wr), .divider_low_wr(divider_low_wr),
		.divider_wdata(divider_wdata));
	task automatic chk8(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic chk1(input string n, input logic e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask : chk1
	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// Reset held four cycles; first request two edges after release
	task automatic do_reset;
		@(posedge ref_clk);
		#1 rst_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : do_reset
	task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
		cpu_bus_model_inst.rd(a, d);
		chk8("byte", e, d);
	endtask : rdchk
	task automatic t_reset;
		do_reset();
		chk8("control", CR_RESET, pe_control_reg);
		chk1("pump", 1'b0, pump_on);
		chk8("prot", 8'h1f, {3'h0, active_protection_reg[4:0]});
		chk8("divh", 8'h87, divider_high);
		chk8("divl", 8'hff, divider_low);
		rdchk(10'h000, ERASED_BYTE);
		$display("test reset done");
	endtask : t_reset
	// Divider of two, then clear block bits in the nonvolatile cell
	task automatic t_setup;
		cpu_bus_model_inst.dw(1'b0, 8'h02);
		cpu_bus_model_inst.dw(1'b1, 8'h80);
		chk8("divl", 8'h02, divider_low);
		cpu_bus_model_inst.op(2'b00, 1'b0, NV_PROT_ADDR, 8'hf0, p, r);
		rdchk(NV_PROT_ADDR, 8'hf0);
		chk8("prot", 8'h00, {4'h0, active_protection_reg[3:0]});
		cpu_bus_model_inst.cw(8'h01);
		chk1("pgm", 1'b0, pe_control_reg[0]);
		$display("test setup done");
	endtask : t_setup
	// Selective programming, second pass timed out by the auto option
	task automatic t_program;
		cpu_bus_model_inst.op(2'b00, 1'b0, 10'h010, 8'hfe, p, r);
		chk1("pump", 1'b1, p);
		cpu_bus_model_inst.op(2'b00, 1'b1, 10'h010, 8'hfd, p, r);
		chk1("auto", 1'b1, p);
		rdchk(10'h010, 8'hfc);
		// Same timed cycle with only the bus stream running
		@(posedge ref_clk);
		#1 {timebase_clock_select, osc_clk_en, bus_clk_en} = 3'b101;
		cpu_bus_model_inst.op(2'b00, 1'b1, 10'h010, 8'hfb, p, r);
		chk1("busclk", 1'b1, p);
		@(posedge ref_clk);
		#1 {timebase_clock_select, osc_clk_en, bus_clk_en} = 3'b010;
		rdchk(10'h010, 8'hf8);
		// Two latched writes, then joint clear of latch and enable
		cpu_bus_model_inst.cw(8'h04);
		cpu_bus_model_inst.mw(10'h020, 8'h00);
		cpu_bus_model_inst.mw(10'h021, 8'h5a);
		cpu_bus_model_inst.cw(8'h05);
		cpu_bus_model_inst.cw(8'h00);
		chk8("control", 8'h04, pe_control_reg);
		cpu_bus_model_inst.cw(8'h00);
		rdchk(10'h020, 8'hff);
		rdchk(10'h021, 8'h5a);
		$display("test program done");
	endtask : t_program
	task automatic t_erase;
		cpu_bus_model_inst.op(2'b01, 1'b0, 10'h010, 8'h00, p, r);
		rdchk(10'h010, 8'hff);
		cpu_bus_model_inst.op(2'b00, 1'b0, 10'h17f, 8'h00, p, r);
		cpu_bus_model_inst.op(2'b00, 1'b0, 10'h180, 8'h00, p, r);
		cpu_bus_model_inst.op(2'b10, 1'b0, 10'h120, 8'h00, p, r);
		rdchk(10'h17f, 8'hff);
		rdchk(10'h180, 8'h00);
		cpu_bus_model_inst.op(2'b11, 1'b0, 10'h000, 8'h00, p, r);
		rdchk(10'h180, 8'hff);
		rdchk(10'h021, 8'hff);
		$display("test erase done");
	endtask : t_erase
	// Erased cell protects all blocks; then only block zero
	task automatic t_protect;
		cpu_bus_model_inst.op(2'b01, 1'b0, NV_PROT_ADDR, 8'h00, p, r);
		rdchk(NV_PROT_ADDR, 8'hff);
		cpu_bus_model_inst.op(2'b00, 1'b0, 10'h010, 8'h00, p, r);
		chk1("pump", 1'b0, p);
		chk1("refused", 1'b1, r);
		rdchk(10'h010, 8'hff);
		cpu_bus_model_inst.op(2'b00, 1'b0, NV_PROT_ADDR, 8'hf1, p, r);
		rdchk(NV_PROT_ADDR, 8'hf1);
		cpu_bus_model_inst.op(2'b00, 1'b0, 10'h07f, 8'h00, p, r);
		rdchk(10'h07f, 8'hff);
		cpu_bus_model_inst.op(2'b00, 1'b0, 10'h080, 8'h00, p, r);
		rdchk(10'h080, 8'h00);
		$display("test protect done");
	endtask : t_protect
	task automatic t_security;
		cpu_bus_model_inst.op(2'b00, 1'b0, NV_PROT_ADDR, 8'hef, p, r);
		do_reset();
		chk1("armed", 1'b0, active_protection_reg[4]);
		cpu_bus_model_inst.op(2'b00, 1'b0, SECURE_FIRST, 8'h00, p, r);
		chk1("refused", 1'b1, r);
		rdchk(SECURE_FIRST, 8'hff);
		cpu_bus_model_inst.op(2'b01, 1'b0, NV_PROT_ADDR, 8'h00, p, r);
		rdchk(NV_PROT_ADDR, 8'he1);
		cpu_bus_model_inst.op(2'b10, 1'b0, 10'h080, 8'h00, p, r);
		rdchk(10'h080, 8'h00);
		cpu_bus_model_inst.op(2'b01, 1'b0, 10'h080, 8'h00, p, r);
		rdchk(10'h080, 8'hff);
		do_reset();
		chk1("armed", 1'b0, active_protection_reg[4]);
		$display("test security done");
	endtask : t_security
	task automatic t_div_security;
		cpu_bus_model_inst.op(2'b00, 1'b0, NV_DIV_HIGH_ADDR, 8'h7f, p, r);
		do_reset();
		chk1("divsec", 1'b0, divider_high[7]);
		cpu_bus_model_inst.dw(1'b0, 8'h05);
		chk8("divl", 8'hff, divider_low);
		cpu_bus_model_inst.op(2'b00, 1'b0, NV_DIV_LOW_ADDR, 8'h00, p, r);
		chk1("refused", 1'b1, r);
		$display("test divider security done");
	endtask : t_div_security
	// Watchdog sized well above the few hundred cycles of the run
	initial begin
		#160000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		t_reset();
		t_setup();
		t_program();
		t_erase();
		t_protect();
		t_security();
		t_div_security();
		tally_and_finish();
	end
endmodule : eeprom_program_erase_control_tb
